// >>> logic/pes_pkg.sv
`default_nettype none
package pes_pkg;

    // ----------------------------------------------------------------
    // Register port map (word addresses on a 4-bit port)
    // ----------------------------------------------------------------
    localparam logic [3:0]  REG_MSR      = 4'h0;
    localparam logic [3:0]  REG_SAVE_RESTORE_PC     = 4'h4;
    localparam logic [3:0]  REG_SAVE_RESTORE_STATE     = 4'h8;
    localparam logic [3:0]  REG_STATUS   = 4'hC;

    // ----------------------------------------------------------------
    // Machine state layout and reset value
    // ----------------------------------------------------------------
    localparam int          MSR_W        = 5;
    localparam logic [4:0]  MSR_RESET    = 5'h10;

    typedef struct packed {
        logic sup;          // Supervisor mode
        logic fe1;          // fp_exc_mode_bit1
        logic fe0;          // fp_exc_mode_bit0
        logic mce;          // machine_check_enable
        logic eie;          // ext_irq_enable
    } pes_msr_t;

    // ----------------------------------------------------------------
    // Vector offsets
    // ----------------------------------------------------------------
    localparam logic [19:0] VEC_RESET    = 20'h00100;
    localparam logic [19:0] VEC_MCHECK   = 20'h00200;
    localparam logic [19:0] VEC_EXT      = 20'h00500;
    localparam logic [19:0] VEC_DEC      = 20'h00800;
    localparam logic [19:0] VEC_SMI      = 20'h00900;
    localparam logic [19:0] VEC_PMON     = 20'h00A00;
    localparam logic [31:0] VEC_BASE     = 32'h00000000;

    // ----------------------------------------------------------------
    // Pin synchroniser lanes
    // ----------------------------------------------------------------
    localparam int          PIN_EXT      = 0;
    localparam int          PIN_SMI      = 1;
    localparam int          PIN_MCP      = 2;
    localparam int          PIN_TEA      = 3;
    localparam int          PIN_SRST     = 4;
    localparam int          PIN_HRST     = 5;
    localparam int          NPIN         = 6;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_DRAIN     = 3'b001,
        ST_HANDLER   = 3'b010,
        ST_CHECKSTOP = 3'b011
    } pes_state_e_t;

    typedef enum logic [3:0] {
        CS_NONE   = 4'h0,
        CS_RESET  = 4'h1,
        CS_MCHECK = 4'h2,
        CS_SYNC   = 4'h3,
        CS_FPIMP  = 4'h4,
        CS_EXT    = 4'h5,
        CS_SMI    = 4'h6,
        CS_DEC    = 4'h7,
        CS_PMON   = 4'h8
    } pes_cause_t;

    // Request into the block from the completion stage
    typedef struct packed {
        logic        valid;      // Oldest instruction carries an exception
        logic        is_fp;      // It is a floating-point exception
        logic [19:0] offset;     // Vector offset of that exception
        logic [31:0] pc;         // Address of the oldest instruction
    } pes_head_t;

    typedef struct packed {
        pes_state_e_t      st;
        pes_cause_t        cause;
        pes_msr_t          machine_state_reg;
        logic [31:0]       save_restore_pc;
        logic [31:0]       save_restore_state;
        logic              mc_pend;
        logic              taken;
        logic              redir_v;
        logic [31:0]       redir_addr;
        logic [31:0]       rdata;
        logic [NPIN-1:0]   sync1;
        logic [NPIN-1:0]   sync2;
        logic [NPIN-1:0]   sync3;
    } pes_regs_t;

endpackage
`default_nettype wire

// >>> logic/pes_sequencer.sv
// Contract
// - Take: save state, supervisor, fetch vector
// - Exceptions taken strictly in program order
// - Instruction exception only at retirement head
// - Async precise needs unmasked and drained buffer
// - Resume address saved into save_restore_pc
// - One at a time; reset/mcheck preempt
// - Several conditions taken one after another
// - Recoverable fp mode behaves as precise
// - Maskable interrupts wait for dispatched completion
// - ext_irq_enable masks the four maskable interrupts
// - External and sys-mgmt pins are maskable
// - Reset and machine check are nonmaskable
// - fp mode 00: full rate, no exception
// - fp_exc_mode_bit0 set: precise fp exception
// - fp mode 01: saved pc may be later
// - Soft or hard reset takes vector 0x100
// - Bus error or pin: vector 0x200
// - Machine check disabled: enter checkstop
// - Any take clears machine_check_enable
// - Bus and cache parity raise machine check
// - Machine check saved state is imprecise
// - External pin: stall dispatch, drain, then take
`default_nettype none
module pes_sequencer
    import pes_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire pes_head_t   head,
    input  wire logic        rob_empty,
    input  wire logic [31:0] retire_next_pc,
    input  wire logic [31:0] fp_later_pc,
    input  wire logic        rfi_valid,
    input  wire logic        decrementer_irq,
    input  wire logic        perf_mon_irq,
    input  wire logic        bus_op_active,
    input  wire logic [3:0]  parity_err,
    input  wire logic        external_interrupt_pin,
    input  wire logic        sys_mgmt_irq_pin,
    input  wire logic        machine_check_pin,
    input  wire logic        transfer_error_ack,
    input  wire logic        soft_reset_pin,
    input  wire logic        hard_reset_pin,
    output logic             redirect_valid,
    output logic      [31:0] redirect_addr,
    output logic             exc_taken,
    output logic             dispatch_stall,
    output logic             checkstop,
    output logic             supervisor,
    output logic             fp_full_rate
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_q_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_q_n = rst_sync[1];

    function automatic logic [31:0] vec_addr(input logic [19:0] off);
        vec_addr = VEC_BASE | {12'h000, off};
    endfunction

    pes_regs_t q;
    pes_regs_t n;

    logic            rst_edge;
    logic            mc_src;
    logic            mc_req;
    logic            fp_ignore;
    logic            fp_imprecise;
    logic            sync_req;
    logic [3:0]      async_src;
    logic            async_req;
    logic            take;
    pes_cause_t      take_cause;
    logic [19:0]     take_off;
    logic [31:0]     take_pc;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        n            = q;
        n.taken      = 1'b0;
        n.redir_v    = 1'b0;
        n.rdata      = 32'h00000000;
        n.sync1      = {hard_reset_pin, soft_reset_pin, transfer_error_ack,
                        machine_check_pin, sys_mgmt_irq_pin, external_interrupt_pin};
        n.sync2      = q.sync1;
        n.sync3      = q.sync2;
        take         = 1'b0;
        take_cause   = CS_NONE;
        take_off     = 20'h00000;
        take_pc      = retire_next_pc;

        // Either reset pin, edge taken so a held pin is not retaken
        rst_edge = (q.sync2[PIN_SRST] & ~q.sync3[PIN_SRST])
                 | (q.sync2[PIN_HRST] & ~q.sync3[PIN_HRST]);
        // Bus error only counts while a device-started transfer is open
        mc_src = (q.sync2[PIN_MCP] & ~q.sync3[PIN_MCP])
               | (q.sync2[PIN_TEA] & ~q.sync3[PIN_TEA] & bus_op_active)
               | (|parity_err);
        mc_req = q.mc_pend | mc_src;
        // Sticky so a one-cycle source survives a busy cycle
        n.mc_pend = mc_req;

        fp_ignore    = ~q.machine_state_reg.fe0 & ~q.machine_state_reg.fe1;
        // fe0 set covers precise and recoverable alike
        fp_imprecise = ~q.machine_state_reg.fe0 & q.machine_state_reg.fe1;
        // Head of retirement means every older instruction is done
        sync_req     = head.valid & ~(head.is_fp & fp_ignore);

        async_src = {perf_mon_irq, decrementer_irq,
                     q.sync2[PIN_SMI], q.sync2[PIN_EXT]};
        // Masking only gates the request; the source is never latched
        async_req = (|async_src) & q.machine_state_reg.eie;

        // ----------------------------------------------------------------
        // Register port
        // ----------------------------------------------------------------
        if (reg_wr) begin
            if (reg_addr == REG_MSR) begin
                n.machine_state_reg = pes_msr_t'(reg_wdata[MSR_W-1:0]);
            end else if (reg_addr == REG_SAVE_RESTORE_PC) begin
                n.save_restore_pc = reg_wdata;
            end else if (reg_addr == REG_SAVE_RESTORE_STATE) begin
                n.save_restore_state = reg_wdata;
            end
        end
        if (reg_rd) begin
            if (reg_addr == REG_MSR) begin
                n.rdata = {27'h0000000, q.machine_state_reg};
            end else if (reg_addr == REG_SAVE_RESTORE_PC) begin
                n.rdata = q.save_restore_pc;
            end else if (reg_addr == REG_SAVE_RESTORE_STATE) begin
                n.rdata = q.save_restore_state;
            end else if (reg_addr == REG_STATUS) begin
                n.rdata = {24'h000000, q.mc_pend, q.st, q.cause};
            end
        end

        // ----------------------------------------------------------------
        // Sequencing
        // ----------------------------------------------------------------
        if (rst_edge) begin
            take       = 1'b1;
            take_cause = CS_RESET;
            take_off   = VEC_RESET;
        end else if (mc_req && q.st != ST_CHECKSTOP) begin
            if (q.machine_state_reg.mce) begin
                // Resume point is the retirement pointer, not the bus op
                take       = 1'b1;
                take_cause = CS_MCHECK;
                take_off   = VEC_MCHECK;
            end else begin
                n.st      = ST_CHECKSTOP;
                n.mc_pend = 1'b0;
            end
        end else begin
            case (q.st)
                ST_IDLE: begin
                    if (sync_req) begin
                        take = 1'b1;
                    end else if (async_req) begin
                        n.st = ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (sync_req) begin
                        take = 1'b1;
                    end else if (!async_req) begin
                        n.st = ST_IDLE;
                    end else if (rob_empty) begin
                        take = 1'b1;
                        if (async_src[0]) begin
                            take_cause = CS_EXT;
                            take_off   = VEC_EXT;
                        end else if (async_src[1]) begin
                            take_cause = CS_SMI;
                            take_off   = VEC_SMI;
                        end else if (async_src[2]) begin
                            take_cause = CS_DEC;
                            take_off   = VEC_DEC;
                        end else begin
                            take_cause = CS_PMON;
                            take_off   = VEC_PMON;
                        end
                    end
                end
                ST_HANDLER: begin
                    // Nothing but reset or machine check is taken until the handler returns
                    if (rfi_valid) begin
                        n.machine_state_reg        = pes_msr_t'(q.save_restore_state[MSR_W-1:0]);
                        n.st         = ST_IDLE;
                        n.cause      = CS_NONE;
                        n.redir_v    = 1'b1;
                        n.redir_addr = q.save_restore_pc;
                    end
                end
                default: begin
                end
            endcase
            if (take && take_cause == CS_NONE) begin
                take_off = head.offset;
                if (head.is_fp && fp_imprecise) begin
                    take_cause = CS_FPIMP;
                    take_pc    = fp_later_pc;
                end else begin
                    take_cause = CS_SYNC;
                    take_pc    = head.pc;
                end
            end
        end

        if (take) begin
            n.save_restore_pc       = take_pc;
            n.save_restore_state       = {23'h000000, take_cause, q.machine_state_reg};
            n.machine_state_reg.sup    = 1'b1;
            n.machine_state_reg.mce    = 1'b0;
            n.machine_state_reg.eie    = 1'b0;
            n.st         = ST_HANDLER;
            n.cause      = take_cause;
            n.taken      = 1'b1;
            n.redir_v    = 1'b1;
            n.redir_addr = vec_addr(take_off);
            if (take_cause == CS_MCHECK || take_cause == CS_RESET) begin
                n.mc_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            q <= '{st: ST_IDLE, cause: CS_NONE, machine_state_reg: pes_msr_t'(MSR_RESET),
                   default: '0};
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata      = q.rdata;
    assign redirect_valid = q.redir_v;
    assign redirect_addr  = q.redir_addr;
    assign exc_taken      = q.taken;
    assign dispatch_stall = (q.st == ST_DRAIN) | (q.st == ST_CHECKSTOP);
    assign checkstop      = (q.st == ST_CHECKSTOP);
    assign supervisor     = q.machine_state_reg.sup;
    assign fp_full_rate   = ~q.machine_state_reg.fe0 & ~q.machine_state_reg.fe1;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_q_n);

    chk_reset_vector: assert property (rst_edge |=>
        exc_taken && redirect_addr == vec_addr(VEC_RESET) && q.cause == CS_RESET)
        else $error("reset did not vector to reset offset");
    chk_mc_vector: assert property (!rst_edge && mc_req && q.machine_state_reg.mce
        && q.st != ST_CHECKSTOP |=> redirect_addr == vec_addr(VEC_MCHECK))
        else $error("machine check did not vector correctly");
    chk_mc_checkstop: assert property (!rst_edge && mc_req && !q.machine_state_reg.mce
        && q.st != ST_CHECKSTOP |=> checkstop && !exc_taken)
        else $error("disabled machine check did not checkstop");
    chk_take_state: assert property (exc_taken |-> supervisor
        && !q.machine_state_reg.mce && q.st == ST_HANDLER && redirect_valid)
        else $error("take did not set supervisor and clear mce");
    chk_take_clears: assert property (take |=> !q.machine_state_reg.mce)
        else $error("machine_check_enable not cleared on take");
    chk_async_drained: assert property (exc_taken && q.cause >= CS_EXT
        |-> $past(rob_empty) && $past(q.st) == ST_DRAIN && $past(q.machine_state_reg.eie))
        else $error("async taken before drain or while masked");
    chk_masked_hold: assert property (q.st == ST_IDLE && !q.machine_state_reg.eie
        && !head.valid && !mc_req && !rst_edge |=> !exc_taken && q.st == ST_IDLE)
        else $error("masked interrupt acted upon");
    chk_one_time: assert property (q.st == ST_HANDLER && !rst_edge
        && !mc_req |=> !exc_taken)
        else $error("second exception taken during handler");
    chk_sync_pc: assert property (q.st == ST_IDLE && head.valid && !head.is_fp
        && !rst_edge && !mc_req |=> exc_taken && q.save_restore_pc == $past(head.pc))
        else $error("save_restore_pc not the faulting address");
    chk_fp_ignore: assert property (q.st == ST_IDLE && head.valid && head.is_fp
        && fp_ignore && !rst_edge && !mc_req && !async_req |=> !exc_taken)
        else $error("fp exception raised in ignore mode");
    chk_drain_stall: assert property (q.st == ST_IDLE && async_req && !head.valid
        && !rst_edge && !mc_req |=> dispatch_stall [*1] ##0 q.st == ST_DRAIN)
        else $error("dispatch not stalled for interrupt");

    // ----------------------------------------------------------------
    // Resume and return checks
    // ----------------------------------------------------------------
    // Saved resume points are compared against the inputs; the return target is compared against save_restore_pc
    chk_rfi_restore: assert property (q.st == ST_HANDLER && rfi_valid
        && !rst_edge && !mc_req |=> redirect_valid && q.st == ST_IDLE
        && redirect_addr == $past(q.save_restore_pc))
        else $error("handler return did not resume at saved pc");
    chk_checkstop_hold: assert property (checkstop && !rst_edge |=> checkstop)
        else $error("checkstop left without reset");
    chk_fp_late_pc: assert property (q.st == ST_IDLE && head.valid && head.is_fp
        && fp_imprecise && !rst_edge && !mc_req |=> exc_taken
        && q.save_restore_pc == $past(fp_later_pc))
        else $error("imprecise fp did not save later pc");
    chk_fp_precise_pc: assert property (q.st == ST_IDLE && head.valid && head.is_fp
        && q.machine_state_reg.fe0 && !rst_edge && !mc_req |=> exc_taken && q.cause == CS_SYNC
        && q.save_restore_pc == $past(head.pc))
        else $error("precise fp did not save faulting pc");
    chk_async_resume: assert property (exc_taken && q.cause >= CS_EXT
        |-> q.save_restore_pc == $past(retire_next_pc))
        else $error("async take saved wrong resume pc");
    // Clearing the enable on take is what keeps maskable sources from nesting
    chk_take_masks: assert property (exc_taken |-> !q.machine_state_reg.eie)
        else $error("maskable interrupts still enabled after take");

    cov_ext_taken: cover property (exc_taken && q.cause == CS_EXT);
    cov_sync_rfi: cover property (exc_taken ##[1:50] redirect_valid && !exc_taken);
    cov_checkstop: cover property (checkstop);
    cov_mc_preempt: cover property (q.st == ST_HANDLER ##1 exc_taken && q.cause == CS_MCHECK);

endmodule
`default_nettype wire

// >>> sim/pes_far_side.sv
`default_nettype none
module pes_far_side
    import pes_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        raise_ext,
    input  wire logic        raise_smi,
    input  wire logic        mcp_req,
    input  wire logic        tea_req,
    input  wire logic        bus_op_active,
    input  wire logic        exc_taken,
    input  wire logic [31:0] redirect_addr,
    output logic             external_interrupt_pin,
    output logic             sys_mgmt_irq_pin,
    output logic             machine_check_pin,
    output logic             transfer_error_ack
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Interrupt sources
    // ----------------------------------------------------------------
    // A source drops its pin only once its own handler has started
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            external_interrupt_pin <= 1'b0;
            sys_mgmt_irq_pin       <= 1'b0;
        end else begin
            if (exc_taken && redirect_addr == VEC_BASE + {12'h000, VEC_EXT}) begin
                external_interrupt_pin <= 1'b0;
            end else if (raise_ext) begin
                external_interrupt_pin <= 1'b1;
            end
            if (exc_taken && redirect_addr == VEC_BASE + {12'h000, VEC_SMI}) begin
                sys_mgmt_irq_pin <= 1'b0;
            end else if (raise_smi) begin
                sys_mgmt_irq_pin <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Memory controller
    // ----------------------------------------------------------------
    assign machine_check_pin  = mcp_req;
    // Errors are only reported against a transfer the device started
    assign transfer_error_ack = tea_req & bus_op_active;
endmodule
`default_nettype wire

// >>> sim/precise_exception_sequencer_test.sv
`default_nettype none
module precise_exception_sequencer_test
    import pes_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, rst_n, reg_wr, reg_rd, rob_empty, rfi_valid, bus_op_active;
    logic        mcp_req, tea_req, soft_reset_pin, hard_reset_pin;
    logic        ext_pin, smi_pin, mcp_pin, tea_pin;
    logic        redirect_valid, exc_taken, dispatch_stall, checkstop, supervisor;
    logic        fp_full_rate;
    logic [3:0]  reg_addr, src, parity_err;
    logic [31:0] reg_wdata, reg_rdata, redirect_addr, retire_next_pc, fp_later_pc;
    pes_head_t   head;
    int          n_mismatch, tests_run;
    logic [4:0]  fm [4] = '{5'h02, 5'h06, 5'h0E, 5'h0A};
    logic [19:0] vec [4] = '{VEC_EXT, VEC_SMI, VEC_DEC, VEC_PMON};
    pes_cause_t  cs [4] = '{CS_EXT, CS_SMI, CS_DEC, CS_PMON};

    pes_sequencer i_pes_sequencer (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .head(head), .rob_empty(rob_empty), .retire_next_pc(retire_next_pc),
        .fp_later_pc(fp_later_pc), .rfi_valid(rfi_valid), .decrementer_irq(src[2]),
        .perf_mon_irq(src[3]), .bus_op_active(bus_op_active), .parity_err(parity_err),
        .external_interrupt_pin(ext_pin), .sys_mgmt_irq_pin(smi_pin),
        .machine_check_pin(mcp_pin), .transfer_error_ack(tea_pin),
        .soft_reset_pin(soft_reset_pin), .hard_reset_pin(hard_reset_pin),
        .redirect_valid(redirect_valid), .redirect_addr(redirect_addr),
        .exc_taken(exc_taken), .dispatch_stall(dispatch_stall), .checkstop(checkstop),
        .supervisor(supervisor), .fp_full_rate(fp_full_rate));

    pes_far_side i_pes_far_side (.clk(clk), .rst_n(rst_n), .raise_ext(src[0]),
        .raise_smi(src[1]), .mcp_req(mcp_req), .tea_req(tea_req),
        .bus_op_active(bus_op_active), .exc_taken(exc_taken), .redirect_addr(redirect_addr),
        .external_interrupt_pin(ext_pin), .sys_mgmt_irq_pin(smi_pin),
        .machine_check_pin(mcp_pin), .transfer_error_ack(tea_pin));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(nm, exp, reg_rdata);
    endtask

    // Looks at the current cycle first, so a one-cycle take is not missed
    // Keyed on exc_taken: a return redirect just before a take must not match
    task automatic wait_take(input logic [19:0] v);
        for (int i = 0; i < 60; i++) begin
            #1;
            if (exc_taken === 1'b1) break;
            @(posedge clk);
        end
        if (exc_taken !== 1'b1) begin
            n_mismatch++;
            $display("mismatch take expected %h seen none", v);
            test_done();
        end else begin
            chk("vector", VEC_BASE + {12'h000, v}, redirect_addr);
            chk("redirect_valid", 32'h1, {31'h0, redirect_valid});
            chk("supervisor", 32'h1, {31'h0, supervisor});
        end
    endtask

    task automatic hold_off(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk("no redirect", 32'h0, {31'h0, redirect_valid});
        end
    endtask

    task automatic rfi(input logic [31:0] a);
        @(posedge clk);
        rfi_valid <= 1'b1;
        @(posedge clk);
        rfi_valid <= 1'b0;
        #1;
        chk("rfi valid", 32'h1, {31'h0, redirect_valid});
        chk("rfi target", a, redirect_addr);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        {reg_wr, reg_rd, rfi_valid, bus_op_active, mcp_req, tea_req} = '0;
        {soft_reset_pin, hard_reset_pin, src, parity_err, reg_addr, reg_wdata} = '0;
        {n_mismatch, tests_run} = '0;
        head = '0;
        rob_empty = 1'b1;
        retire_next_pc = 32'h0000_2000;
        fp_later_pc = 32'h0000_3008;
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(REG_MSR, 32'h10, "msr reset");
        wr(4'h2, 32'hFFFF_FFFF);
        rd(4'h2, 32'h0, "unmapped");
        wr(REG_MSR, 32'h03);
        rd(REG_MSR, 32'h03, "msr");
        @(posedge clk);
        head <= '{1'b1, 1'b0, 20'h00700, 32'h0000_1000};
        wait_take(20'h00700);
        rd(REG_SAVE_RESTORE_STATE, {23'h0, CS_SYNC, 5'h03}, "save_restore_state sync");
        rd(REG_MSR, 32'h10, "msr after take");
        head.pc <= 32'h0000_1004;
        hold_off(10);
        wr(REG_MSR, 32'h12);
        @(posedge clk);
        parity_err <= 4'h1;
        @(posedge clk);
        parity_err <= 4'h0;
        wait_take(VEC_MCHECK);
        rfi(retire_next_pc);
        wait_take(20'h00700);
        head.valid <= 1'b0;
        rfi(32'h0000_1004);
        for (int k = 0; k < 4; k++) begin
            wr(REG_MSR, {27'h0, fm[k]});
            @(posedge clk);
            head <= '{1'b1, 1'b1, 20'h00700, 32'h0000_1100};
            #1;
            chk("fp_full_rate", {31'h0, k == 0}, {31'h0, fp_full_rate});
            if (k == 0) begin
                hold_off(10);
                head.valid <= 1'b0;
            end else begin
                wait_take(20'h00700);
                head.valid <= 1'b0;
                rfi(k == 3 ? fp_later_pc : 32'h0000_1100);
            end
        end
        wr(REG_MSR, 32'h02);
        @(posedge clk);
        src <= 4'h1;
        @(posedge clk);
        src <= 4'h0;
        hold_off(15);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            rob_empty <= 1'b0;
            src[k] <= 1'b1;
            wr(REG_MSR, 32'h03);
            hold_off(6);
            chk("dispatch_stall", 32'h1, {31'h0, dispatch_stall});
            rob_empty <= 1'b1;
            wait_take(vec[k]);
            src <= 4'h0;
            rd(REG_SAVE_RESTORE_STATE, {23'h0, cs[k], 5'h03}, "save_restore_state async");
            rd(REG_SAVE_RESTORE_PC, retire_next_pc, "save_restore_pc async");
            rfi(retire_next_pc);
        end
        for (int k = 0; k < 6; k++) begin
            wr(REG_MSR, 32'h02);
            @(posedge clk);
            mcp_req <= (k == 0);
            {bus_op_active, tea_req} <= {2{k == 1}};
            parity_err <= (k > 1) ? 4'h1 << (k - 2) : 4'h0;
            @(posedge clk);
            parity_err <= 4'h0;
            wait_take(VEC_MCHECK);
            {mcp_req, tea_req, bus_op_active} <= '0;
            rd(REG_SAVE_RESTORE_STATE, {23'h0, CS_MCHECK, 5'h02}, "save_restore_state mcheck");
            rfi(retire_next_pc);
        end
        wr(REG_MSR, 32'h00);
        @(posedge clk);
        mcp_req <= 1'b1;
        hold_off(8);
        chk("checkstop", 32'h1, {31'h0, checkstop});
        chk("stall", 32'h1, {31'h0, dispatch_stall});
        mcp_req <= 1'b0;
        soft_reset_pin <= 1'b1;
        wait_take(VEC_RESET);
        soft_reset_pin <= 1'b0;
        #1;
        chk("checkstop", 32'h0, {31'h0, checkstop});
        rd(REG_SAVE_RESTORE_STATE, {23'h0, CS_RESET, 5'h00}, "save_restore_state reset");
        hard_reset_pin <= 1'b1;
        wait_take(VEC_RESET);
        hard_reset_pin <= 1'b0;
        test_done();
    end
endmodule
`default_nettype wire
